// ===== design/sslo_ctrl.sv
// sslo_ctrl: status LED patterns and overvoltage response with an APB register slave.
// assumes condition and voltage inputs are synchronous to pclk and already filtered.
//
// Functional notes
// - drive the status LED pin with a pattern chosen from current conditions
// - charging: breathing light, 2 s dimming phase, 4 s full cycle
// - charge current below 500 mA means fully charged: LED steadily on
// - mismatch or non-PD source: 1 s on, 1 s off
// - refuse power from a non-PD source and show the mismatch pattern
// - overvoltage fault: 300 ms on, 300 ms off
// - on overvoltage send a hard reset request to the source
// - enable the discharge path at once on overvoltage
// - threshold is 110% of contract above 18 V, else contract plus 2 V
// - blank overvoltage detection 90 ms after a downward contract step
// - turn the bus switch gate off within 50 ms of a trip
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sslo_ctrl #(
	parameter int MS_TICK_CYC = sslo_pkg::MS_TICK_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// system conditions
	input wire sslo_pkg::sslo_cond_t cond,
	input wire sslo_pkg::sslo_volt_t volt,
	// pins and controls
	output logic status_led_pin,
	output logic hard_reset_req,
	output logic discharge_en,
	output logic vbus_gate_en
);
	import sslo_pkg::*;

	localparam logic [15:0] TICK_LAST = 16'(MS_TICK_CYC - 1);

	// apb
	logic [31:0] ctrl_r, ctrl_nxt, prdata_r, prdata_nxt, rd_val;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, hit, fault_clr;
	// overvoltage
	logic [15:0] thr_r, thr_nxt, contract_q_r;
	logic [11:0] blank_r, blank_nxt;
	logic fault_r, fault_nxt, hr_r, hr_nxt, dis_r, dis_nxt, gate_r, gate_nxt;
	logic ov_trip, step_dn, led_en, ovp_en;
	// pattern
	sslo_pat_t pat_r, pat_nxt;
	logic [15:0] pre_r, pre_nxt;
	logic [11:0] ms_r, ms_nxt, lvl;
	logic [7:0] pwm_r, pwm_nxt;
	logic led_r, led_nxt, tick;

	assign led_en = ctrl_r[CTRL_LED_BIT];
	assign ovp_en = ctrl_r[CTRL_OVP_BIT];

	// one wait state: pready rises the cycle after penable
	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			CTRL_OFF: rd_val = ctrl_r;
			STAT_OFF: rd_val = {26'h0, gate_r, dis_r, fault_r, pat_r};
			THR_OFF: rd_val = {16'h0, thr_r};
			VBUS_OFF: rd_val = {16'h0, volt.vbus_mv};
			default: begin
				rd_val = 32'h0;
				hit = 1'b0;
			end
		endcase
		pready_nxt = psel && penable && !pready_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (pready_nxt) begin
			prdata_nxt = pwrite ? 32'h0 : rd_val;
			pslverr_nxt = !hit;
		end
		ctrl_nxt = ctrl_r;
		fault_clr = 1'b0;
		if (psel && penable && pready_r && pwrite && paddr == CTRL_OFF) begin
			ctrl_nxt = pwdata & CTRL_MASK;
			fault_clr = pwdata[CTRL_CLR_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// overvoltage detection and response
	always_comb begin
		if (volt.contract_mv > OVP_HI_MV) begin
			thr_nxt = 16'((32'(volt.contract_mv) * OVP_PCT) / PCT_DIV);
		end else begin
			thr_nxt = volt.contract_mv + OVP_ADD_MV;
		end
		step_dn = volt.contract_mv < contract_q_r;
		// trip only on a settled threshold, outside the blanking window
		// a stale threshold right after an upward contract step would false-trip on the new level
		ov_trip = ovp_en && cond.contract_ok && blank_r == 12'h0 && !step_dn
			&& volt.contract_mv == contract_q_r && volt.vbus_mv > thr_r;
		blank_nxt = blank_r;
		if (step_dn) begin
			blank_nxt = OVP_BLANK_MS;
		end else if (tick && blank_r != 12'h0) begin
			blank_nxt = blank_r - 12'h1;
		end
		// a trip in the same cycle as a software clear keeps the fault
		fault_nxt = ov_trip ? 1'b1 : (fault_clr ? 1'b0 : fault_r);
		hr_nxt = ov_trip && !fault_r;
		dis_nxt = ov_trip;
		// one cycle to gate off, far inside the allowed window
		gate_nxt = cond.contract_ok && !cond.v_mismatch && !cond.p_mismatch && !cond.non_pd
			&& !ov_trip && !fault_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_r <= OVP_ADD_MV;
			contract_q_r <= 16'h0;
			blank_r <= 12'h0;
			fault_r <= 1'b0;
			hr_r <= 1'b0;
			dis_r <= 1'b0;
			gate_r <= 1'b0;
		end else begin
			thr_r <= thr_nxt;
			contract_q_r <= volt.contract_mv;
			blank_r <= blank_nxt;
			fault_r <= fault_nxt;
			hr_r <= hr_nxt;
			dis_r <= dis_nxt;
			gate_r <= gate_nxt;
		end
	end

	assign hard_reset_req = hr_r;
	assign discharge_en = dis_r;
	assign vbus_gate_en = gate_r;

	// pattern selection and LED timing
	always_comb begin
		tick = pre_r == TICK_LAST;
		pre_nxt = tick ? 16'h0 : pre_r + 16'h1;
		pwm_nxt = pwm_r + 8'h1;
		if (fault_r) begin
			pat_nxt = PAT_FAULT;
		end else if (cond.v_mismatch || cond.p_mismatch || cond.non_pd) begin
			pat_nxt = PAT_MISMATCH;
		end else if (cond.charger_on && cond.charge_ma < FULL_MA) begin
			pat_nxt = PAT_FULL;
		end else if (cond.charger_on) begin
			pat_nxt = PAT_CHARGE;
		end else begin
			pat_nxt = PAT_OFF;
		end
		// restart the cycle on a pattern change so the blink patterns begin lit and breathing begins dark
		if (pat_nxt != pat_r) begin
			ms_nxt = 12'h0;
		end else if (tick) begin
			ms_nxt = (ms_r == sslo_pat_cyc(pat_r) - 12'h1) ? 12'h0 : ms_r + 12'h1;
		end else begin
			ms_nxt = ms_r;
		end
		lvl = (ms_r < BRTH_DIM_MS) ? ms_r : BRTH_CYC_MS - 12'h1 - ms_r;
		unique case (pat_r)
			PAT_OFF: led_nxt = 1'b0;
			PAT_FULL: led_nxt = 1'b1;
			PAT_CHARGE: led_nxt = pwm_r < lvl[10:3];
			PAT_MISMATCH: led_nxt = ms_r < MIS_PH_MS;
			PAT_FAULT: led_nxt = ms_r < FLT_PH_MS;
		endcase
		led_nxt = led_nxt && led_en;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 16'h0;
			pwm_r <= 8'h0;
			ms_r <= 12'h0;
			pat_r <= PAT_OFF;
			led_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			pwm_r <= pwm_nxt;
			ms_r <= ms_nxt;
			pat_r <= pat_nxt;
			led_r <= led_nxt;
		end
	end

	assign status_led_pin = led_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	led_gate_a: assert property (!led_en |=> !led_r)
		else $error("led lit while disabled");
	brth_wrap_a: assert property (pat_r == PAT_CHARGE && pat_nxt == PAT_CHARGE && tick
		&& ms_r == 12'd3999 |=> ms_r == 12'h0)
		else $error("breathing cycle not 4000 ms");
	full_on_a: assert property (pat_r == PAT_FULL && led_en |=> led_r)
		else $error("full charge led not steady");
	mis_phase_a: assert property (pat_r == PAT_MISMATCH && pat_nxt == PAT_MISMATCH && led_en
		&& ms_r == 12'd1000 |=> !led_r)
		else $error("mismatch off phase wrong");
	nonpd_refuse_a: assert property (cond.non_pd |=> !gate_r ##0 (fault_r || pat_r == PAT_MISMATCH))
		else $error("non pd source accepted");
	flt_phase_a: assert property (pat_r == PAT_FAULT && led_en && ms_r < 12'd300 |=> led_r)
		else $error("fault on phase wrong");
	hard_rst_a: assert property (ov_trip && !fault_r |=> hr_r ##1 !hr_r)
		else $error("hard reset pulse missing");
	dis_path_a: assert property (ov_trip |=> dis_r && fault_r)
		else $error("discharge not enabled");
	thr_low_a: assert property ($past(presetn) && $past(volt.contract_mv) <= 16'd18000
		|-> thr_r == $past(volt.contract_mv) + 16'd2000)
		else $error("low range threshold wrong");
	blank_win_a: assert property (step_dn |=> !ov_trip [*8])
		else $error("trip inside blanking window");
	gate_off_a: assert property (ov_trip |=> !gate_r)
		else $error("gate still on after trip");
	prio_pat_a: assert property (fault_r |=> pat_r == PAT_FAULT)
		else $error("fault not top priority");

	cv_fault_c: cover property (ov_trip ##1 hr_r);
	cv_charge_c: cover property (pat_r == PAT_CHARGE && led_r);
	cv_mis_c: cover property (pat_r == PAT_MISMATCH && led_r);
	cv_full_c: cover property (pat_r == PAT_FULL && led_r);
endmodule : sslo_ctrl

// ===== pkg/sslo_pkg.sv
// sslo_pkg: constants, types and helpers for the sink status LED / overvoltage block.
// assumes a 25 MHz pclk; pattern phases run on a 1 ms tick derived from it, while the breathing pwm steps every pclk.
package sslo_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_TICK_DEF = CLK_HZ / MS_PER_S;

	// pattern and protection times, in ms
	localparam logic [11:0] BRTH_DIM_MS = 12'd2000;
	localparam logic [11:0] BRTH_CYC_MS = 12'd4000;
	localparam logic [11:0] MIS_PH_MS = 12'd1000;
	localparam logic [11:0] MIS_CYC_MS = 12'd2000;
	localparam logic [11:0] FLT_PH_MS = 12'd300;
	localparam logic [11:0] FLT_CYC_MS = 12'd600;
	localparam logic [11:0] OVP_BLANK_MS = 12'd90;
	localparam logic [11:0] GATE_OFF_MAX_MS = 12'd50;

	// electrical thresholds
	localparam logic [15:0] FULL_MA = 16'd500;
	localparam logic [15:0] OVP_HI_MV = 16'd18000;
	localparam logic [15:0] OVP_ADD_MV = 16'd2000;
	localparam int OVP_PCT = 110;
	localparam int PCT_DIV = 100;

	// register map (byte addresses)
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] THR_OFF = 8'h08;
	localparam logic [7:0] VBUS_OFF = 8'h0C;
	localparam int CTRL_LED_BIT = 0;
	localparam int CTRL_OVP_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
	localparam logic [31:0] CTRL_RST = 32'h0000_0003;

	typedef enum logic [2:0] {PAT_OFF, PAT_FULL, PAT_CHARGE, PAT_MISMATCH, PAT_FAULT} sslo_pat_t;

	typedef struct packed {
		logic contract_ok;
		logic charger_on;
		logic v_mismatch;
		logic p_mismatch;
		logic non_pd;
		logic [15:0] charge_ma;
	} sslo_cond_t;

	typedef struct packed {
		logic [15:0] vbus_mv;
		logic [15:0] contract_mv;
	} sslo_volt_t;

	function automatic logic [11:0] sslo_pat_cyc(input sslo_pat_t p);
		unique case (p)
			PAT_CHARGE: sslo_pat_cyc = BRTH_CYC_MS;
			PAT_MISMATCH: sslo_pat_cyc = MIS_CYC_MS;
			PAT_FAULT: sslo_pat_cyc = FLT_CYC_MS;
			default: sslo_pat_cyc = 12'd1;
		endcase
	endfunction : sslo_pat_cyc
endpackage : sslo_pkg

// ===== tb/sslo_partner.sv
// sslo_partner: stand-in for the lamp and the pd source adapter.
// assumes sslo_ctrl outputs are registers on pclk; counts lit cycles and hard resets.
`timescale 1ns/1ps
module sslo_partner (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench commands
	input wire logic [15:0] contract_mv,
	input wire logic ovp_cmd,
	// device pins
	input wire logic status_led_pin,
	input wire logic hard_reset_req,
	output sslo_pkg::sslo_volt_t volt,
	// observations
	output logic [31:0] lit_cnt,
	output logic [31:0] hr_cnt
);
	import sslo_pkg::*;
	// a faulty source overshoots by 2.1 V and does not back off on hard reset
	assign volt = {ovp_cmd ? contract_mv + 16'h0834 : contract_mv, contract_mv};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lit_cnt <= 32'h0;
			hr_cnt <= 32'h0;
		end else begin
			lit_cnt <= lit_cnt + {31'h0, status_led_pin};
			hr_cnt <= hr_cnt + {31'h0, hard_reset_req};
		end
	end
endmodule : sslo_partner

// ===== tb/sslo_ctrl_bench.sv
// sslo_ctrl_bench: apb-driven self-check of led patterns and overvoltage response.
// assumes MS_TICK_CYC of 10, so one ms is ten pclk cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module sslo_ctrl_bench;
	import sslo_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovp_cmd, e;
	logic status_led_pin, hard_reset_req, discharge_en, vbus_gate_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, lit_cnt, hr_cnt, l0;
	logic [15:0] contract_mv;
	sslo_cond_t cond;
	sslo_volt_t volt;
	int err_count = 0;
	int n_checks = 0;
	int i;
	sslo_ctrl #(.MS_TICK_CYC(10)) u_sslo_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .cond, .volt, .status_led_pin,
		.hard_reset_req, .discharge_en, .vbus_gate_en);
	sslo_partner u_sslo_partner (.pclk, .presetn, .contract_mv, .ovp_cmd, .status_led_pin,
		.hard_reset_req, .volt, .lit_cnt, .hr_cnt);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic final_report();
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// one full apb transfer; returns one idle cycle later so strobes never re-toggle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		if (k >= 50) begin
			err_count++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cond = '0;
		contract_mv = 16'h1388;
		ovp_cmd = 1'b0;
		cyc(3);
		presetn <= 1'b1;
		cyc(1);
		`CHK("led_rst", 1'b0, status_led_pin)
		apb(1'b0, CTRL_OFF, 32'h0);
		`CHK("ctrl_rst", CTRL_RST, q)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 1'b1, e)
		cond.contract_ok <= 1'b1;
		cond.charger_on <= 1'b1;
		cond.charge_ma <= 16'h01F3;
		cyc(3);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("full", 32'h21, q)
		`CHK("led_full", 1'b1, status_led_pin)
		cond.charge_ma <= 16'h01F4;
		cyc(3);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("charge", 32'h22, q)
		// each mismatch source alone: voltage, power, non-pd
		for (int k = 0; k < 3; k++) begin
			cond[18:16] <= 3'h4 >> k;
			cyc(3);
			apb(1'b0, STAT_OFF, 32'h0);
			`CHK("mismatch", 32'h03, q)
			`CHK("gate_mis", 1'b0, vbus_gate_en)
		end
		l0 = lit_cnt;
		cyc(20000);
		`CHK("mis_lit", 32'h2710, lit_cnt - l0)
		contract_mv <= 16'h4E20;
		cyc(3);
		apb(1'b0, THR_OFF, 32'h0);
		`CHK("thr_hi", 32'h55F0, q)
		// a downward step opens the blanking window while vbus overshoots
		contract_mv <= 16'h1388;
		ovp_cmd <= 1'b1;
		cyc(3);
		apb(1'b0, THR_OFF, 32'h0);
		`CHK("thr_lo", 32'h1B58, q)
		cyc(790);
		`CHK("blanked", 32'h0, hr_cnt)
		i = 0;
		while (hr_cnt !== 32'h1 && i < 300) begin
			cyc(1);
			i++;
		end
		`CHK("hard_reset", 32'h1, hr_cnt)
		if (i >= 300) final_report();
		`CHK("discharge", 1'b1, discharge_en)
		`CHK("gate_off", 1'b0, vbus_gate_en)
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("fault", 32'h1C, q)
		l0 = lit_cnt;
		cyc(6000);
		`CHK("flt_lit", 32'h0BB8, lit_cnt - l0)
		ovp_cmd <= 1'b0;
		cond[18:16] <= 3'h0;
		cyc(3);
		apb(1'b1, CTRL_OFF, 32'h7);
		cyc(3);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("cleared", 32'h22, q)
		`CHK("one_reset", 32'h1, hr_cnt)
		apb(1'b1, CTRL_OFF, 32'h2);
		cond.charge_ma <= 16'h01F3;
		cyc(3);
		`CHK("led_off", 1'b0, status_led_pin)
		final_report();
	end
endmodule : sslo_ctrl_bench
